// file: include/distortion_alarm_pkg.sv
// constants shared by the distortion alarm block timer
// assumes a 20 mhz clock and a wishbone classic register bus with 32-bit data
// What this block does
// - sample blocking once at each program-cycle start
// - blocking arrives on its own dedicated input
// - unblocked pick-up asserts start, starts delay
// - blocked pick-up asserts blocked, nothing more
// - later blocking clears start like pick-up release
// - blocking activation issues display and stamped event
// - stage forcing lets software switch drive blocking
// - definite delay, 5 ms steps, default 10 s
// - events from start/alarm/blocked changes, only enabled
// - six event codes, per-event on/off store selection
// - stored events carry time stamp and values
// - rolling store of twelve most recent records
// - records written only on on transitions
// - record holds time, event, phase values, group
// - pick-up when any phase exceeds threshold, enabled
// - release below 97 percent of threshold
package distortion_alarm_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CYCLE_US = 5000; // program cycle 5 ms
    localparam int unsigned CYCLE_CLKS = CYCLE_US * (CLK_HZ / 1000000);
    localparam logic [18:0] DELAY_RESET = 19'h007d0; // 10.000 s in 5 ms steps
    localparam logic [18:0] DELAY_MAX = 19'h57e40; // 1800 s in 5 ms steps
    localparam int unsigned RECORDS = 12;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] THRESH_OFS = 8'h04;
    localparam logic [7:0] DELAY_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] TIME_OFS = 8'h18;
    localparam logic [7:0] REC_SEL_OFS = 8'h1c;
    localparam logic [7:0] REC_HEAD_OFS = 8'h20;
    localparam logic [7:0] REC_VAL_OFS = 8'h24;
    localparam logic [7:0] REC_TIME_OFS = 8'h28;
    localparam logic [7:0] EVSEL_OFS = 8'h2c;
    // ctrl fields
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_FORCE = 1;
    localparam int unsigned CTRL_SWBLK = 2;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam logic [15:0] THRESH_RESET = 16'h03e8; // 10.00 percent
    localparam logic [11:0] EVSEL_RESET = 12'h03f; // all six codes stored
    // event codes, on form even, off form odd
    typedef enum logic [2:0] {
        EV_START_ON = 3'h0, EV_START_OFF = 3'h1, EV_ALARM_ON = 3'h2,
        EV_ALARM_OFF = 3'h3, EV_BLK_ON = 3'h4, EV_BLK_OFF = 3'h5
    } event_code_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_START = 3'b010, ST_BLOCKED = 3'b100
    } state_type;
endpackage

// file: design/distortion_alarm_block_timer.sv
// distortion alarm stage control: pick-up, blocking, delay, events, records
// assumes wishbone classic master, phase values in 0.01 percent units, ms time base
`timescale 1ns/100ps
`default_nettype none
module distortion_alarm_block_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // measurement and matrix side
    input wire logic [15:0] thd_l1_i,
    input wire logic [15:0] thd_l2_i,
    input wire logic [15:0] thd_l3_i,
    input wire logic block_i,
    input wire logic [2:0] setting_group_i,
    // outputs
    output logic start_o,
    output logic alarm_o,
    output logic blocked_o,
    output logic event_valid_o,
    output logic [2:0] event_code_o,
    output logic [31:0] event_time_o,
    output logic [47:0] event_values_o,
    output logic display_o,
    output logic irq_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] ctrl_q; // enable, force, software block
    logic [15:0] thresh_q; // pick-up threshold
    logic [18:0] delay_q; // delay in program cycles
    logic [11:0] evsel_q; // per-code store selection
    logic [2:0] irq_stat_q; // start, alarm, blocked on events
    logic [2:0] irq_mask_q;
    logic [3:0] rec_sel_q; // record read selector
    logic [3:0] head_q; // next record slot
    logic [16:0] tick_q; // program cycle prescaler, wide enough for 100000 clocks
    logic [15:0] ms_pre_q; // millisecond prescaler
    logic [31:0] ms_q; // millisecond time stamp
    logic pickup_q;
    logic blk_s_q; // blocking sampled at cycle start
    logic [18:0] count_q; // delay counter
    distortion_alarm_pkg::state_type state_q;
    logic start_q, alarm_q, blocked_q;
    logic start_p, alarm_p, blocked_p; // previous values for edges
    logic [31:0] rec_time [distortion_alarm_pkg::RECORDS];
    logic [47:0] rec_val [distortion_alarm_pkg::RECORDS];
    logic [5:0] rec_head [distortion_alarm_pkg::RECORDS]; // event code, group
    logic tick;
    logic blk_src;
    logic over, under;
    logic [23:0] rel_lim; // 97 percent of threshold, scaled; full 16-bit range fits
    logic wr, rd;
    logic [2:0] on_ev, off_ev;
    logic [5:0] pend_q; // events waiting for their slot on the event port
    logic [5:0] ev_new; // selected events raised this clock, indexed by code
    logic [5:0] ev_all; // waiting plus new events
    logic [5:0] ev_pick; // the one event sent this clock
    logic [2:0] ev_code; // its code
    assign tick = (tick_q == 17'(distortion_alarm_pkg::CYCLE_CLKS - 1));
    assign wr = cyc_i && stb_i && we_i && !ack_o;
    assign rd = cyc_i && stb_i && !we_i && !ack_o;
    // forcing mode replaces the matrix input with the software switch
    assign blk_src = ctrl_q[distortion_alarm_pkg::CTRL_FORCE] ?
                     ctrl_q[distortion_alarm_pkg::CTRL_SWBLK] : block_i;
    // any phase above threshold picks up
    assign over = (thd_l1_i > thresh_q) || (thd_l2_i > thresh_q) || (thd_l3_i > thresh_q);
    // compare x*100 < thr*97 to avoid division
    assign rel_lim = 24'((32'(thresh_q) * 32'd97) >> 2);
    assign under = (24'((32'(thd_l1_i) * 32'd100) >> 2) < rel_lim) &&
                   (24'((32'(thd_l2_i) * 32'd100) >> 2) < rel_lim) &&
                   (24'((32'(thd_l3_i) * 32'd100) >> 2) < rel_lim);
    assign on_ev = {blocked_q & ~blocked_p, alarm_q & ~alarm_p, start_q & ~start_p};
    assign off_ev = {~blocked_q & blocked_p, ~alarm_q & alarm_p, ~start_q & start_p};

    // ----------------------------------------
    // time bases
    // ----------------------------------------
    // program cycle prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_q <= 17'h00000;
        end else begin
            tick_q <= tick_q + 17'h00001;
        end
    end
    // millisecond time stamp counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_pre_q <= 16'h0000;
            ms_q <= 32'h00000000;
        end else if (ms_pre_q == 16'(distortion_alarm_pkg::CLK_HZ / 1000 - 1)) begin
            ms_pre_q <= 16'h0000;
            ms_q <= ms_q + 32'h00000001;
        end else begin
            ms_pre_q <= ms_pre_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // pick-up, blocking, delay
    // ----------------------------------------
    // all stage logic advances only at program cycle starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pickup_q <= 1'b0;
            blk_s_q <= 1'b0;
            count_q <= 19'h00000;
            state_q <= distortion_alarm_pkg::ST_IDLE;
            start_q <= 1'b0;
            alarm_q <= 1'b0;
            blocked_q <= 1'b0;
        end else if (tick) begin
            blk_s_q <= blk_src;
            // hysteresis: hold until all phases fall below 97 percent
            if (!ctrl_q[distortion_alarm_pkg::CTRL_EN]) begin
                pickup_q <= 1'b0;
            end else if (over) begin
                pickup_q <= 1'b1;
            end else if (under) begin
                pickup_q <= 1'b0;
            end
            case (state_q)
                distortion_alarm_pkg::ST_IDLE: begin
                    if (pickup_q && !blk_s_q) begin
                        state_q <= distortion_alarm_pkg::ST_START;
                        start_q <= 1'b1;
                        count_q <= 19'h00001;
                    end else if (pickup_q) begin
                        state_q <= distortion_alarm_pkg::ST_BLOCKED;
                        blocked_q <= 1'b1;
                    end
                end
                distortion_alarm_pkg::ST_START: begin
                    // blocking after start behaves as a release
                    if (!pickup_q || blk_s_q) begin
                        state_q <= distortion_alarm_pkg::ST_IDLE;
                        start_q <= 1'b0;
                        alarm_q <= 1'b0;
                        count_q <= 19'h00000;
                    end else if (count_q >= delay_q) begin
                        alarm_q <= 1'b1;
                    end else begin
                        count_q <= count_q + 19'h00001;
                    end
                end
                distortion_alarm_pkg::ST_BLOCKED: begin
                    // blocked pick-up is not processed further
                    if (!pickup_q) begin
                        state_q <= distortion_alarm_pkg::ST_IDLE;
                        blocked_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= distortion_alarm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // events and records
    // ----------------------------------------
    // gather selected edges by code; start and alarm can fall together,
    // so losers wait in pend_q instead of being dropped
    always_comb begin
        ev_new = {off_ev[2] & evsel_q[5], on_ev[2] & evsel_q[4],
                  off_ev[1] & evsel_q[3], on_ev[1] & evsel_q[2],
                  off_ev[0] & evsel_q[1], on_ev[0] & evsel_q[0]};
        ev_all = pend_q | ev_new;
        ev_pick = 6'h00;
        ev_code = 3'h0;
        // highest code wins the port this clock
        for (int k = 0; k < 6; k++) begin
            if (ev_all[k]) begin
                ev_pick = 6'(6'h01 << k);
                ev_code = 3'(k);
            end
        end
    end
    // one event per cycle; the rest follow on later clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_p <= 1'b0;
            alarm_p <= 1'b0;
            blocked_p <= 1'b0;
            event_valid_o <= 1'b0;
            event_code_o <= 3'h0;
            event_time_o <= 32'h00000000;
            event_values_o <= 48'h0;
            display_o <= 1'b0;
            head_q <= 4'h0;
            pend_q <= 6'h00;
        end else begin
            event_valid_o <= 1'b0;
            display_o <= 1'b0;
            start_p <= start_q;
            alarm_p <= alarm_q;
            blocked_p <= blocked_q;
            event_time_o <= ms_q;
            event_values_o <= {thd_l3_i, thd_l2_i, thd_l1_i};
            pend_q <= 6'h00;
            if (ctrl_q[distortion_alarm_pkg::CTRL_EN]) begin
                pend_q <= ev_all & ~ev_pick;
                event_valid_o <= |ev_all;
                event_code_o <= ev_code;
                display_o <= on_ev[2];
                if (on_ev != 3'h0) begin
                    head_q <= (head_q == 4'(distortion_alarm_pkg::RECORDS - 1)) ? 4'h0 : head_q + 4'h1;
                end
            end
        end
    end
    // record store: the highest on edge of the cycle wins the slot
    always_ff @(posedge clk_i) begin
        if (ctrl_q[distortion_alarm_pkg::CTRL_EN] && on_ev != 3'h0) begin
            rec_time[head_q] <= ms_q;
            rec_val[head_q] <= {thd_l3_i, thd_l2_i, thd_l1_i};
            rec_head[head_q] <= {(on_ev[2] ? 3'h4 : on_ev[1] ? 3'h2 : 3'h0), setting_group_i};
        end
    end
    // stage outputs straight from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_o <= 1'b0;
            alarm_o <= 1'b0;
            blocked_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            start_o <= start_q;
            alarm_o <= alarm_q;
            blocked_o <= blocked_q;
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // wishbone registers
    // ----------------------------------------
    // writes; status set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= distortion_alarm_pkg::CTRL_RESET;
            thresh_q <= distortion_alarm_pkg::THRESH_RESET;
            delay_q <= distortion_alarm_pkg::DELAY_RESET;
            evsel_q <= distortion_alarm_pkg::EVSEL_RESET;
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            rec_sel_q <= 4'h0;
        end else begin
            if (wr && sel_i[0]) begin
                case (adr_i)
                    distortion_alarm_pkg::CTRL_OFS: ctrl_q <= {29'h0, dat_i[2:0]};
                    distortion_alarm_pkg::THRESH_OFS: thresh_q <= dat_i[15:0];
                    distortion_alarm_pkg::DELAY_OFS:
                        delay_q <= (dat_i[18:0] > distortion_alarm_pkg::DELAY_MAX) ?
                                   distortion_alarm_pkg::DELAY_MAX : dat_i[18:0];
                    distortion_alarm_pkg::IRQ_MASK_OFS: irq_mask_q <= dat_i[2:0];
                    distortion_alarm_pkg::REC_SEL_OFS:
                        rec_sel_q <= (dat_i[3:0] < 4'(distortion_alarm_pkg::RECORDS)) ? dat_i[3:0] : 4'h0;
                    distortion_alarm_pkg::EVSEL_OFS: evsel_q <= dat_i[11:0];
                    default: ;
                endcase
            end
            irq_stat_q <= (irq_stat_q &
                          ~((wr && sel_i[0] && adr_i == distortion_alarm_pkg::IRQ_STAT_OFS) ? dat_i[2:0] : 3'h0))
                          | (ctrl_q[distortion_alarm_pkg::CTRL_EN] ? on_ev : 3'h0);
        end
    end
    // reads and one-cycle ack; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (rd) begin
                case (adr_i)
                    distortion_alarm_pkg::CTRL_OFS: dat_o <= ctrl_q;
                    distortion_alarm_pkg::THRESH_OFS: dat_o <= {16'h0, thresh_q};
                    distortion_alarm_pkg::DELAY_OFS: dat_o <= {13'h0, delay_q};
                    distortion_alarm_pkg::STATUS_OFS: dat_o <= {26'h0, blk_s_q, pickup_q, 1'b0, blocked_q, alarm_q, start_q};
                    distortion_alarm_pkg::IRQ_STAT_OFS: dat_o <= {29'h0, irq_stat_q};
                    distortion_alarm_pkg::IRQ_MASK_OFS: dat_o <= {29'h0, irq_mask_q};
                    distortion_alarm_pkg::TIME_OFS: dat_o <= ms_q;
                    distortion_alarm_pkg::REC_SEL_OFS: dat_o <= {28'h0, rec_sel_q};
                    distortion_alarm_pkg::REC_HEAD_OFS: dat_o <= {22'h0, head_q, rec_head[rec_sel_q]};
                    distortion_alarm_pkg::REC_VAL_OFS: dat_o <= {16'h0, rec_val[rec_sel_q][15:0]};
                    distortion_alarm_pkg::REC_TIME_OFS: dat_o <= rec_time[rec_sel_q];
                    distortion_alarm_pkg::EVSEL_OFS: dat_o <= {20'h0, evsel_q};
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // distortion_alarm_block_timer
`default_nettype wire

// file: test/event_buffer_model.sv
// far side model: blocking matrix source and event buffer sink
// assumes the bench requests blocking just after a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module event_buffer_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic block_req_i,
    input wire logic event_valid_i,
    input wire logic [2:0] event_code_i,
    input wire logic [47:0] event_values_i,
    input wire logic display_i,
    output logic block_o,
    output logic [5:0] seen_o,
    output logic [47:0] start_values_o,
    output logic display_seen_o
);
    // ----------------------------------------
    // blocking matrix output
    // ----------------------------------------
    // one dedicated line, driven straight from the bench request with no gating
    assign block_o = block_req_i;
    // ----------------------------------------
    // event capture
    // ----------------------------------------
    // sticky record of codes seen, values of the start on event
    always @(posedge clk_i) begin
        if (rst_i) begin
            seen_o <= 6'h00;
            start_values_o <= 48'h0;
            display_seen_o <= 1'b0;
        end else if (event_valid_i) begin
            seen_o[event_code_i] <= 1'b1;
            if (event_code_i == 3'h0) begin
                start_values_o <= event_values_i;
            end
        end
        // display pulse may stand apart from the event pulse
        if (!rst_i && display_i) begin
            display_seen_o <= 1'b1;
        end
    end
endmodule // event_buffer_model
`default_nettype wire

// file: test/distortion_alarm_monitor.sv
// port checker for the distortion alarm block timer
// bound to the top module, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module distortion_alarm_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic start_o,
    input wire logic alarm_o,
    input wire logic blocked_o,
    input wire logic event_valid_o,
    input wire logic [2:0] event_code_o,
    input wire logic display_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // bus steps
    // ----------------------------------------
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    a_bus_answer: assert property (s_take |=> s_answer) else $error("bus answer late or long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    // ----------------------------------------
    // stage outputs
    // ----------------------------------------
    a_alarm_needs_start: assert property (alarm_o |-> start_o) else $error("alarm without start");
    a_alarm_clears: assert property ($fell(start_o) |-> !alarm_o) else $error("alarm outlived start");
    a_start_block_excl: assert property (!(start_o && blocked_o)) else $error("start and blocked");
    a_start_event: assert property ($rose(start_o) |-> ##[0:2] (event_valid_o && event_code_o == 3'h0))
        else $error("no start event");
    a_block_display: assert property ($rose(blocked_o) |-> ##[0:2] display_o) else $error("no display");
    a_code_range: assert property (event_valid_o |-> event_code_o <= 3'h5) else $error("bad code");
endmodule // distortion_alarm_monitor
bind distortion_alarm_block_timer distortion_alarm_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .start_o(start_o), .alarm_o(alarm_o),
    .blocked_o(blocked_o), .event_valid_o(event_valid_o), .event_code_o(event_code_o), .display_o(display_o));
`default_nettype wire

// file: test/distortion_alarm_block_timer_tb.sv
// self-checking bench for the distortion alarm block timer
// full 5 ms program cycles, so the run is long
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module distortion_alarm_block_timer_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, block_req = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [15:0] thd_l1_i = 16'h0000;
    logic [2:0] setting_group_i = 3'h5, event_code_o;
    logic ack_o, block_i, start_o, alarm_o, blocked_o, event_valid_o, display_o, irq_o, disp_seen;
    logic [47:0] event_values_o, start_vals;
    logic [5:0] seen;
    int n_mismatch = 0, compares = 0, cycles = 0;
    always #25 clk_i = ~clk_i;
    distortion_alarm_block_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .thd_l1_i(thd_l1_i), .thd_l2_i(16'h0000), .thd_l3_i(16'h0000), .block_i(block_i),
        .setting_group_i(setting_group_i), .start_o(start_o), .alarm_o(alarm_o), .blocked_o(blocked_o),
        .event_valid_o(event_valid_o), .event_code_o(event_code_o), .event_time_o(),
        .event_values_o(event_values_o), .display_o(display_o), .irq_o(irq_o));
    event_buffer_model i_far (.clk_i(clk_i), .rst_i(rst_i), .block_req_i(block_req),
        .event_valid_i(event_valid_o), .event_code_i(event_code_o), .event_values_i(event_values_o),
        .display_i(display_o), .block_o(block_i), .seen_o(seen), .start_values_o(start_vals),
        .display_seen_o(disp_seen));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // classic cycle: hold until ack is sampled, read data taken there
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        // look at settled outputs mid-cycle; ack still stands at the next rise
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        if (n >= 50) n_mismatch++;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // bounded wait for a stage output to reach a level
    task wait_for(input int which, input logic lvl);
        int n;
        n = 0;
        while (((which == 0) ? start_o : (which == 1) ? alarm_o : blocked_o) !== lvl && n < 350000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 350000) n_mismatch++;
        // let queued events reach the far-side model
        repeat (4) @(negedge clk_i);
    endtask
    task final_report;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        wb(1'b0, distortion_alarm_pkg::CTRL_OFS, 32'h0);
        `CHK("ctrl", distortion_alarm_pkg::CTRL_RESET, rd)
        wb(1'b0, distortion_alarm_pkg::THRESH_OFS, 32'h0);
        `CHK("thresh", {16'h0, distortion_alarm_pkg::THRESH_RESET}, rd)
        wb(1'b0, distortion_alarm_pkg::DELAY_OFS, 32'h0);
        `CHK("delay", {13'h0, distortion_alarm_pkg::DELAY_RESET}, rd)
        wb(1'b0, distortion_alarm_pkg::EVSEL_OFS, 32'h0);
        `CHK("evsel", {20'h0, distortion_alarm_pkg::EVSEL_RESET}, rd)
        wb(1'b1, 8'hf0, 32'hffffffff);
        wb(1'b0, 8'hf0, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        wb(1'b1, distortion_alarm_pkg::DELAY_OFS, 32'h000fffff);
        wb(1'b0, distortion_alarm_pkg::DELAY_OFS, 32'h0);
        `CHK("delay clamp", {13'h0, distortion_alarm_pkg::DELAY_MAX}, rd)
        wb(1'b1, distortion_alarm_pkg::DELAY_OFS, 32'h0);
    endtask
    // unblocked pick-up: start, event, irq, record, then alarm
    task t_start;
        thd_l1_i <= 16'h03e9;
        wait_for(0, 1'b1);
        `CHK("start", 1'b1, start_o)
        `CHK("start on seen", 1'b1, seen[0])
        `CHK("start values", {32'h0, 16'h03e9}, start_vals)
        `CHK("irq masked", 1'b0, irq_o)
        wb(1'b0, distortion_alarm_pkg::IRQ_STAT_OFS, 32'h0);
        `CHK("irq stat", 1'b1, rd[0])
        wb(1'b1, distortion_alarm_pkg::IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("irq on", 1'b1, irq_o)
        wb(1'b1, distortion_alarm_pkg::IRQ_STAT_OFS, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("irq clear", 1'b0, irq_o)
        wb(1'b1, distortion_alarm_pkg::REC_SEL_OFS, 32'h0);
        wb(1'b0, distortion_alarm_pkg::REC_HEAD_OFS, 32'h0);
        `CHK("rec code group", 6'h05, rd[5:0])
        wb(1'b0, distortion_alarm_pkg::REC_VAL_OFS, 32'h0);
        `CHK("rec value", 32'h000003e9, rd)
        wait_for(1, 1'b1);
        `CHK("alarm", 1'b1, alarm_o)
        `CHK("alarm on seen", 1'b1, seen[2])
    endtask
    // later blocking drops start; software block then blocks a new pick-up
    task t_block;
        int n;
        block_req <= 1'b1;
        wait_for(0, 1'b0);
        `CHK("start cleared", 1'b0, start_o)
        `CHK("alarm cleared", 1'b0, alarm_o)
        `CHK("start off seen", 1'b1, seen[1])
        wb(1'b1, distortion_alarm_pkg::CTRL_OFS, 32'h7);
        block_req <= 1'b0;
        thd_l1_i <= 16'h0000;
        n = 0;
        do begin
            wb(1'b0, distortion_alarm_pkg::STATUS_OFS, 32'h0);
            n++;
        end while (rd[4] !== 1'b0 && n < 100000);
        thd_l1_i <= 16'h0800;
        wait_for(2, 1'b1);
        `CHK("blocked", 1'b1, blocked_o)
        `CHK("no start", 1'b0, start_o)
        `CHK("display", 1'b1, disp_seen)
        `CHK("blocked on seen", 1'b1, seen[4])
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    // ceiling covers about fifteen program cycles of waiting
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 1500000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_start();
        t_block();
        final_report();
    end
endmodule // distortion_alarm_block_timer_tb
`default_nettype wire
